// ---- rtl/ext_bus_pkg.sv ----
package ext_bus_pkg;
  localparam logic [23:0] CTRL_ADDR = 24'hffe070;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int WIDTH_HI = 7;
  localparam int WIDTH_LO = 6;
  localparam int MEM_HI = 5;
  localparam int MEM_LO = 4;
  localparam logic [3:0] CTRL_RSVD_MASK = 4'h0;
  localparam logic [1:0] WIDTH_NONE = 2'h0;
  localparam logic [1:0] WIDTH_8 = 2'h1;
  localparam logic [1:0] MEM_128K = 2'h0;
  localparam logic [1:0] MEM_64K = 2'h1;
  localparam logic [1:0] MEM_32K = 2'h2;
  localparam logic [1:0] MEM_NONE = 2'h3;
  localparam logic [23:0] MEM_TOP_128K = 24'h01ffff;
  localparam logic [23:0] MEM_TOP_64K = 24'h00ffff;
  localparam logic [23:0] MEM_TOP_32K = 24'h007fff;
  localparam int NUM_CS = 6;
  localparam int LOW_CS_COUNT = 2;
  localparam logic [4:0] MAX_WAITS = 5'h1f;
  // axi-lite register map, byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CS_BASE = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h40;
  // per chip-select word layout
  localparam int CS_EN_BIT = 8;
  localparam int CS_ISA_BIT = 9;
  localparam int CS_HIWAIT_BIT = 10;
  localparam int WAIT_HI = 3;
  localparam int POST_HI = 5;
  localparam int POST_LO = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_HOLD = 2'b10,
    ST_DONE = 2'b11
  } acc_state_t;
endpackage

// ---- rtl/pin_sync.sv ----
module pin_sync (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pin,
  output logic level
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  // a change counts only once stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      level <= 1'b0;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level <= s3_r;
      end
    end
  end
endmodule

// ---- rtl/external_bus_wait_and_control.sv ----
// Contract
// - one stall cycle per wait, at most 31
// - waits from wait count plus post-read count
// - isa mode delays read strobe half clock
// - isa mode adds one wait to reads
// - width field: none, 8-bit, 16-bit
// - memory size field: 128k, 64k, 32k, none
// - hold input only when pin assigned
// - on-chip wins, then highest chip select
// - waits only while chip select enabled
// - wait count field is plain binary
//
// Decided for this implementation: the AXI4-Lite slave port.
module external_bus_wait_and_control (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic acc_req,
  input wire logic acc_write,
  input wire logic [23:0] acc_addr,
  input wire logic [5:0] cs_hit,
  output logic acc_done,
  output logic cpu_stall,
  output logic internal_sel,
  output logic [5:0] cs_active,
  output logic rd_strobe,
  output logic wr_strobe,
  output logic [1:0] bus_width_select,
  output logic [1:0] internal_memory_size,
  input wire logic hold_pin,
  input wire logic hold_pin_assigned
);
  localparam int N = ext_bus_pkg::NUM_CS;
  // the port widths above serve exactly six chip selects
  if (N != 6) begin : g_bad_n
    $error("six chip selects expected");
  end

  logic [7:0] ctrl_r;
  logic [10:0] cs_cfg_r [N];
  logic aw_held_r, w_held_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  ext_bus_pkg::acc_state_t st_r, st_nxt;
  logic [4:0] cnt_r;
  logic [2:0] sel_r;
  logic wr_r, isa_r, rd_half_r;
  logic hold_level;

  pin_sync u_hold (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(hold_pin),
    .level(hold_level)
  );

  // axi-lite write side: address and data in either order
  wire do_write = aw_held_r && w_held_r && !s_axi_bvalid;
  wire [7:0] w_idx = awaddr_r - ext_bus_pkg::REG_CS_BASE;
  wire w_ctrl = awaddr_r == ext_bus_pkg::REG_CTRL;
  wire w_cs = awaddr_r >= ext_bus_pkg::REG_CS_BASE &&
    awaddr_r < ext_bus_pkg::REG_CS_BASE + 8'h18 && awaddr_r[1:0] == 2'h0;
  wire [2:0] w_sel = w_idx[4:2];
  assign s_axi_awready = !aw_held_r;
  assign s_axi_wready = !w_held_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ext_bus_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_held_r) begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held_r) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (w_ctrl || w_cs) ? ext_bus_pkg::RESP_OKAY
                                        : ext_bus_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // reserved low bits always store zero, whatever software writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= ext_bus_pkg::CTRL_RESET;
    end else if (do_write && w_ctrl && wstrb_r[0]) begin
      ctrl_r <= {wdata_r[7:4], ext_bus_pkg::CTRL_RSVD_MASK};
    end
  end

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_cs
      // cs0 resets with wait and post-read fields all ones but enable clear, so it inserts no waits
      localparam logic [10:0] RST = (g == 0) ? 11'h03f : 11'h000;
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          cs_cfg_r[g] <= RST;
        end else if (do_write && w_cs && w_sel == 3'(g)) begin
          if (wstrb_r[0]) cs_cfg_r[g][5:0] <= wdata_r[5:0];
          if (wstrb_r[1]) begin
            cs_cfg_r[g][9:8] <= wdata_r[9:8];
            // extended count only on high chip selects
            cs_cfg_r[g][10] <= (g >= ext_bus_pkg::LOW_CS_COUNT) ?
              wdata_r[10] : 1'b0;
          end
        end
      end
    end
  endgenerate

  // axi-lite read side
  wire [7:0] r_idx = s_axi_araddr - ext_bus_pkg::REG_CS_BASE;
  wire r_cs = s_axi_araddr >= ext_bus_pkg::REG_CS_BASE &&
    s_axi_araddr < ext_bus_pkg::REG_CS_BASE + 8'h18 &&
    s_axi_araddr[1:0] == 2'h0;
  wire r_ctrl = s_axi_araddr == ext_bus_pkg::REG_CTRL;
  wire r_stat = s_axi_araddr == ext_bus_pkg::REG_STATUS;
  wire [10:0] r_cfg = cs_cfg_r[r_idx[4:2]];
  wire [31:0] stat_word = {21'h0, hold_level, sel_r, st_r, cnt_r};
  wire [31:0] rd_word = r_ctrl ? {24'h0, ctrl_r} :
    r_cs ? {21'h0, r_cfg[10:8], 2'h0, r_cfg[5:0]} :
    r_stat ? stat_word : 32'h0;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= ext_bus_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= (r_ctrl || r_cs || r_stat) ? ext_bus_pkg::RESP_OKAY
                                                : ext_bus_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  assign bus_width_select =
    ctrl_r[ext_bus_pkg::WIDTH_HI:ext_bus_pkg::WIDTH_LO];
  assign internal_memory_size =
    ctrl_r[ext_bus_pkg::MEM_HI:ext_bus_pkg::MEM_LO];
  wire [23:0] mem_top =
    internal_memory_size == ext_bus_pkg::MEM_128K ? ext_bus_pkg::MEM_TOP_128K :
    internal_memory_size == ext_bus_pkg::MEM_64K ? ext_bus_pkg::MEM_TOP_64K :
    ext_bus_pkg::MEM_TOP_32K;
  wire mem_hit = internal_memory_size != ext_bus_pkg::MEM_NONE &&
    acc_addr <= mem_top;
  wire ext_on = bus_width_select != ext_bus_pkg::WIDTH_NONE;

  // on-chip first, then highest chip select
  logic [2:0] pick;
  logic any_cs;
  always_comb begin
    pick = 3'h0;
    any_cs = 1'b0;
    for (int i = 0; i < N; i++) begin
      if (cs_hit[i]) begin
        pick = 3'(i);
        any_cs = 1'b1;
      end
    end
  end
  wire go_ext = acc_req && !mem_hit && any_cs && ext_on;
  wire [10:0] pcfg = cs_cfg_r[pick];
  wire p_en = pcfg[ext_bus_pkg::CS_EN_BIT];
  wire p_isa = pcfg[ext_bus_pkg::CS_ISA_BIT];
  // binary wait count; plus post-read count
  wire [4:0] base_w = {pcfg[ext_bus_pkg::CS_HIWAIT_BIT],
                       pcfg[ext_bus_pkg::WAIT_HI:0]};
  wire [4:0] post_w = acc_write ? 5'h00 :
    {3'h0, pcfg[ext_bus_pkg::POST_HI:ext_bus_pkg::POST_LO]};
  wire [5:0] sum_w = {1'b0, base_w} + {1'b0, post_w} +
    {5'h0, p_isa && !acc_write};
  // waits only when enabled; capped at 31
  wire [4:0] waits = !p_en ? 5'h00 :
    (sum_w > {1'b0, ext_bus_pkg::MAX_WAITS}) ? ext_bus_pkg::MAX_WAITS :
    sum_w[4:0];
  wire hold_on = hold_pin_assigned && hold_level;

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      ext_bus_pkg::ST_IDLE: if (go_ext) begin
        st_nxt = (waits == 5'h00) ? ext_bus_pkg::ST_HOLD
                                  : ext_bus_pkg::ST_WAIT;
      end
      ext_bus_pkg::ST_WAIT: if (cnt_r == 5'h01) begin
        st_nxt = ext_bus_pkg::ST_HOLD;
      end
      ext_bus_pkg::ST_HOLD: if (!hold_on) begin
        st_nxt = ext_bus_pkg::ST_DONE;
      end
      ext_bus_pkg::ST_DONE: st_nxt = ext_bus_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= ext_bus_pkg::ST_IDLE;
      cnt_r <= 5'h00;
      sel_r <= 3'h0;
      wr_r <= 1'b0;
      isa_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      if (st_r == ext_bus_pkg::ST_IDLE && go_ext) begin
        cnt_r <= waits;
        sel_r <= pick;
        wr_r <= acc_write;
        isa_r <= p_isa;
      end else if (st_r == ext_bus_pkg::ST_WAIT) begin
        cnt_r <= cnt_r - 5'h01;
      end
    end
  end

  always_ff @(negedge aclk) begin
    if (!aresetn) begin
      rd_half_r <= 1'b0;
    end else begin
      rd_half_r <= st_r != ext_bus_pkg::ST_IDLE && !wr_r;
    end
  end

  wire busy = st_r != ext_bus_pkg::ST_IDLE;
  assign cpu_stall = busy && st_r != ext_bus_pkg::ST_DONE;
  assign acc_done = st_r == ext_bus_pkg::ST_DONE;
  assign internal_sel = acc_req && mem_hit;
  assign cs_active = busy ? (6'h01 << sel_r) : 6'h00;
  assign wr_strobe = busy && wr_r;
  assign rd_strobe = busy && !wr_r && (isa_r ? rd_half_r : 1'b1);

  a_wait_cap: assert property (@(posedge aclk) disable iff (!aresetn)
    st_r == ext_bus_pkg::ST_WAIT |-> cnt_r != 5'h00)
    else $error("wait count zero while waiting");
  a_wait_len: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r == ext_bus_pkg::ST_IDLE && go_ext && waits == 5'h02 && !hold_on)
    |=> cpu_stall [*3] ##1 acc_done)
    else $error("two waits did not give three stall cycles");
  a_disabled_nowait: assert property (@(posedge aclk)
    disable iff (!aresetn)
    (st_r == ext_bus_pkg::ST_IDLE && go_ext && !p_en) |=>
    st_r == ext_bus_pkg::ST_HOLD)
    else $error("waits inserted on disabled chip select");
  a_isa_read: assert property (@(posedge aclk) disable iff (!aresetn)
    (go_ext && p_en && p_isa && !acc_write && sum_w < 6'h20) |->
    waits == base_w + post_w + 5'h01)
    else $error("isa read lacks extra wait");
  a_hold_extend: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r == ext_bus_pkg::ST_HOLD && hold_on) |=> !acc_done)
    else $error("access finished under hold");
  a_hold_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r == ext_bus_pkg::ST_HOLD && !hold_pin_assigned) |=> acc_done)
    else $error("unassigned hold pin extended access");
  a_internal_wins: assert property (@(posedge aclk)
    disable iff (!aresetn)
    (st_r == ext_bus_pkg::ST_IDLE && acc_req && mem_hit) |=>
    st_r == ext_bus_pkg::ST_IDLE)
    else $error("external access on internal address");
  a_low_cs_cap: assert property (@(posedge aclk) disable iff (!aresetn)
    !cs_cfg_r[0][ext_bus_pkg::CS_HIWAIT_BIT] &&
    !cs_cfg_r[1][ext_bus_pkg::CS_HIWAIT_BIT])
    else $error("low chip select got extended wait");
  a_rsvd_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_r[3:0] == 4'h0)
    else $error("reserved control bits set");
endmodule

// ---- verif/ext_devices.sv ----
module ext_devices (
  input wire logic aclk,
  input wire logic acc_req,
  input wire logic [23:0] acc_addr,
  input wire logic [5:0] cs_active,
  input wire logic slow,
  output logic [5:0] cs_hit,
  output logic hold_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  // overlapping windows, slow part may answer on any chip select
  assign cs_hit = acc_req ? {acc_addr[23:19], acc_addr[18] | acc_addr[16]} :
                  6'h00;
  always @(posedge aclk) begin
    cnt <= (cs_active == 6'h00) ? 0 : cnt + 1;
  end
  // slow part holds only once selected
  assign hold_pin = slow && (cs_active != 6'h00) && (cnt < 12);
endmodule

// ---- verif/testbench.sv ----
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, acc_req, acc_write, acc_done;
  logic cpu_stall, internal_sel, rd_strobe, wr_strobe, hold_pin;
  logic hold_assigned, slow;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, bws, ims;
  logic [23:0] acc_addr;
  logic [5:0] cs_hit, cs_active;
  logic [1:0] strb;
  int error_cnt, cmp_count, cyc;
  time rd_rise;
  localparam int CS[10] = '{0, 1, 1, 1, 1, 3, 3, 2, 2, 5};
  localparam int CFG[10] = '{'h03f, 'h100, 'h50f, 'h135, 'h135, 'h325,
                             'h325, 'h73f, 'h50a, 'h001};
  localparam int WR[10] = '{0, 1, 0, 0, 1, 0, 1, 0, 1, 0};
  localparam int EXP[10] = '{1, 1, 16, 9, 6, 9, 6, 32, 27, 1};
  localparam logic [23:0] TOP[4] = '{24'h01ffff, 24'h00ffff, 24'h007fff,
                                     24'h000000};
  external_bus_wait_and_control i_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .acc_req(acc_req),
    .acc_write(acc_write), .acc_addr(acc_addr), .cs_hit(cs_hit),
    .acc_done(acc_done), .cpu_stall(cpu_stall), .internal_sel(internal_sel),
    .cs_active(cs_active), .rd_strobe(rd_strobe), .wr_strobe(wr_strobe),
    .bus_width_select(bws), .internal_memory_size(ims),
    .hold_pin(hold_pin), .hold_pin_assigned(hold_assigned));
  ext_devices i_dev (.aclk(aclk), .acc_req(acc_req), .acc_addr(acc_addr),
    .cs_active(cs_active), .slow(slow), .cs_hit(cs_hit),
    .hold_pin(hold_pin));
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  always @(posedge rd_strobe) rd_rise = $time;
  // far above the few hundred cycles the sequence needs
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt = error_cnt + 1;
      summarize();
    end
  end
  task automatic summarize;
    $display("mismatches=%0d compares=%0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // ready is combinational, so sample it mid-cycle and act on the edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic aw_ok, w_ok, b_ok;
    logic [1:0] r;
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'h7;
    b_ok = 1'b0;
    while (!b_ok) begin
      @(negedge aclk);
      aw_ok = awvalid && awready;
      w_ok = wvalid && wready;
      b_ok = bvalid;
      r = bresp;
      @(posedge aclk);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    chk(r, er);
    @(posedge aclk);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] er);
    logic ar_ok, r_ok;
    logic [31:0] d;
    logic [1:0] r;
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    r_ok = 1'b0;
    while (!r_ok) begin
      @(negedge aclk);
      ar_ok = arvalid && arready;
      r_ok = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ar_ok) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    chk(d, e);
    chk(r, er);
    @(posedge aclk);
  endtask
  task automatic acc(input logic [23:0] a, input logic w,
                     output logic [31:0] n, output logic [5:0] act);
    acc_addr <= a;
    acc_write <= w;
    acc_req <= 1'b1;
    n = 0;
    do begin
      @(negedge aclk);
      if (cpu_stall === 1'b1) begin
        n = n + 1;
        act = cs_active;
        strb = {wr_strobe, rd_strobe};
      end
    end while (acc_done !== 1'b1);
    @(posedge aclk);
    acc_req <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic noacc(input logic [23:0] a, input logic e);
    acc_addr <= a;
    acc_req <= 1'b1;
    repeat (4) @(posedge aclk);
    @(negedge aclk);
    chk(cpu_stall, 0);
    chk(internal_sel, e);
    chk(cs_active, 0);
    @(posedge aclk);
    acc_req <= 1'b0;
    @(posedge aclk);
  endtask
  initial begin
    logic [31:0] n;
    logic [5:0] act;
    logic [7:0] ca;
    {aresetn, awvalid, wvalid, bready, arvalid, rready} <= '0;
    {acc_req, acc_write, hold_assigned, slow} <= '0;
    {awaddr, araddr, wdata, acc_addr} <= '0;
    wstrb <= 4'hf;
    {error_cnt, cmp_count, cyc} = '0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rchk(ext_bus_pkg::REG_CTRL, 32'h0, ext_bus_pkg::RESP_OKAY);
    rchk(ext_bus_pkg::REG_CS_BASE, 32'h3f, ext_bus_pkg::RESP_OKAY);
    rchk(8'h80, 32'h0, ext_bus_pkg::RESP_SLVERR);
    wr(8'h84, 32'h1, ext_bus_pkg::RESP_SLVERR);
    for (int m = 0; m < 4; m++) begin
      // low control bits written as zero
      wr(ext_bus_pkg::REG_CTRL, {26'h0, m[1:0], 4'h0}, 2'h0);
      chk(ims, m);
      chk(bws, 0);
      noacc(TOP[m], m != 3);
      noacc(TOP[m] + 24'h1, 1'b0);
    end
    wr(ext_bus_pkg::REG_CTRL, 32'h50, 2'h0);
    chk(bws, 2'h1);
    acc(24'h010000, 1'b0, n, act);
    chk(n, 1);
    chk(act, 6'h01);
    wr(ext_bus_pkg::REG_CTRL, 32'hc0, 2'h0);
    rchk(ext_bus_pkg::REG_CTRL, 32'hc0, 2'h0);
    chk(bws, 2'h3);
    noacc(24'h010000, 1'b1);
    for (int i = 0; i < 10; i++) begin
      ca = 8'(8'h10 + 4 * CS[i]);
      wr(ca, CFG[i], 2'h0);
      rchk(ca, CFG[i] & (CS[i] < 2 ? 'h3ff : 'h7ff), 2'h0);
      acc(24'h040000 << CS[i], WR[i] != 0, n, act);
      chk(n, EXP[i]);
      chk(act, 6'h01 << CS[i]);
      chk(strb, WR[i] != 0 ? 2'h2 : 2'h1);
      if (WR[i] == 0) chk(32'(rd_rise % 4), CFG[i][9] ? 0 : 2);
    end
    acc(24'h140000, 1'b0, n, act);
    chk(act, 6'h04);
    chk(n, 27);
    // upper width code 1x: two waits on a write to cs3
    wr(ext_bus_pkg::REG_CTRL, 32'h80, 2'h0);
    chk(bws, 2'h2);
    wr(8'h1c, 32'h102, 2'h0);
    acc(24'h200000, 1'b1, n, act);
    chk(n, 3);
    chk(act, 6'h08);
    chk(strb, 2'h2);
    wr(8'h20, 32'h106, 2'h0);
    slow <= 1'b1;
    acc(24'h400000, 1'b0, n, act);
    chk(n, 7);
    hold_assigned <= 1'b1;
    acc(24'h400000, 1'b0, n, act);
    chk(n >= 13 && n <= 22, 1);
    // idle, count run out, cs4 last selected, hold released
    rchk(ext_bus_pkg::REG_STATUS, 32'h200, 2'h0);
    summarize();
  end
endmodule
